/* File: pkg/oaa_map.vh */
// Constants for the operand access and alignment unit.
`ifndef OAA_MAP_VH
`define OAA_MAP_VH
// ==========================================================
// Operand size codes
`define OAA_SZ_BYTE   3'h0
`define OAA_SZ_WORD   3'h1
`define OAA_SZ_DWORD  3'h2
`define OAA_SZ_QWORD  3'h3
`define OAA_SZ_DQWORD 3'h4
// ==========================================================
// Scale codes (shift amounts)
`define OAA_SCALE_1   2'h0
`define OAA_SCALE_2   2'h1
`define OAA_SCALE_4   2'h2
`define OAA_SCALE_8   2'h3
// ==========================================================
// Register numbers with special addressing meaning
`define OAA_REG_SP    3'h4
`define OAA_REG_FP    3'h5
// ==========================================================
// Segment codes
`define OAA_SEG_DATA  1'h0
`define OAA_SEG_STACK 1'h1
// ==========================================================
// Bus beat width in bytes and its low address bits
`define OAA_BEAT_BYTES 5'h08
`define OAA_BEAT_LSB   3
// ==========================================================
// I/O port address width
`define OAA_IO_AW     16
`endif

/* File: rtl/oaa_access_unit.v */
// Operand access unit: address forming, split bus cycles, alignment faults, I/O ports.
// How it works
// - Offset is base plus index shifted by scale plus displacement, any part optional.
// - I/O space has 65,536 byte ports; word and doubleword ports also allowed.
// - I/O port number comes from the immediate or the port index register.
// - Operand sizes are byte, word, doubleword, quadword and double quadword.
// - Multi-byte operands are little-endian; low byte at the operand address.
// - Word, doubleword and quadword accesses at any address never fault.
// - Word/doubleword crossing 4 bytes, quadword crossing 8 bytes take two cycles.
// - Odd-address word inside one boundary is a single bus cycle.
// - Aligned-only double quadword faults when address is not divisible by 16.
// - Unaligned-allowed double quadword completes with extra bus cycles.
// - Unsigned integers are plain binary over full size range.
// - Sign bit sits at bit 7, 15, 31 or 63 by size.
// - Signed ranges are full two's complement for each size.
// - Integer indefinite is sign set, all other bits clear.
// - Scale applies only with an index; stack pointer never acts as index.
// - Stack or frame pointer base selects stack segment, else data segment.
`timescale 1ns/10ps
`include "oaa_map.vh"

module oaa_access_unit (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst,
  // Request from the pipeline
  input  wire         reqValid,
  input  wire         reqWrite,
  input  wire         reqIo,
  input  wire         reqIoImm,
  input  wire [2:0]   reqSize,
  input  wire         reqAlignReq,
  input  wire         baseEn,
  input  wire [2:0]   baseSel,
  input  wire [31:0]  baseVal,
  input  wire         indexEn,
  input  wire [2:0]   indexSel,
  input  wire [31:0]  indexVal,
  input  wire [1:0]   scale,
  input  wire [31:0]  disp,
  input  wire [15:0]  ioImm,
  input  wire [15:0]  portIndexReg,
  input  wire [127:0] wrData,
  // Answer to the pipeline
  output reg          busy,
  output reg          done,
  output reg  [127:0] rdData,
  output reg          generalProtectionFault,
  output reg          badIndex,
  output reg          segSel,
  output reg          rdSign,
  output reg  [63:0]  intIndefinite,
  // Memory and I/O bus
  output reg          busReq,
  output reg          busWrite,
  output reg          busIo,
  output reg  [31:0]  busAddr,
  output reg  [7:0]   busBe,
  output reg  [63:0]  busWdata,
  input  wire [63:0]  busRdata,
  input  wire         busAck
);

  // ==========================================================
  // States
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_BEAT = 4'h2;
  localparam [3:0] ST_NEXT = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ==========================================================
  // Helpers

  // Byte count of an operand size.
  function [4:0] sizeBytes;
    input [2:0] sz;
    begin
      case (sz)
        `OAA_SZ_BYTE:  sizeBytes = 5'h01;
        `OAA_SZ_WORD:  sizeBytes = 5'h02;
        `OAA_SZ_DWORD: sizeBytes = 5'h04;
        `OAA_SZ_QWORD: sizeBytes = 5'h08;
        default:       sizeBytes = 5'h10;
      endcase
    end
  endfunction

  // Split boundary mask: 4 bytes for word and doubleword, 8 otherwise.
  function [31:0] boundMask;
    input [2:0] sz;
    begin
      if (sz == `OAA_SZ_WORD || sz == `OAA_SZ_DWORD)
        boundMask = 32'h00000003;
      else
        boundMask = 32'h00000007;
    end
  endfunction

  // ==========================================================
  // Effective address, segment and port number
  reg  [31:0] scaledIdx;
  wire [31:0] effAddr;
  wire        idxValid = indexEn && (indexSel != `OAA_REG_SP);
  always @* begin
    scaledIdx = 32'h0;
    if (idxValid)
      scaledIdx = indexVal << scale;
  end
  assign effAddr = (baseEn ? baseVal : 32'h0) + scaledIdx + disp;
  wire stackBase = baseEn && (baseSel == `OAA_REG_SP || baseSel == `OAA_REG_FP);
  wire [15:0] ioPort = reqIoImm ? ioImm : portIndexReg;

  // Alignment test for double quadwords that demand it.
  wire dqMisalign = (reqSize == `OAA_SZ_DQWORD) && reqAlignReq &&
                    (effAddr[3:0] != 4'h0);

  // ==========================================================
  // Operation registers
  reg [3:0]   st_q;
  reg [31:0]  addr_q;
  reg [4:0]   left_q;
  reg [4:0]   done_q;
  reg [2:0]   size_q;
  reg         wr_q;
  reg         io_q;
  reg [127:0] wbuf_q;

  // Bytes served in the current beat: up to the next split boundary.
  wire [31:0] bmask    = io_q ? 32'h00000003 : boundMask(size_q);
  wire [4:0]  roomLeft = bmask[4:0] - (addr_q[4:0] & bmask[4:0]) + 5'h01;
  wire [4:0]  beatCnt  = (left_q < roomLeft) ? left_q : roomLeft;
  wire [2:0]  laneOff  = addr_q[2:0];

  // Byte enables of a beat.
  reg [7:0]  beMask;
  integer    i;
  always @* begin
    beMask = 8'h00;
    for (i = 0; i < 8; i = i + 1)
      if (i >= laneOff && i < laneOff + beatCnt)
        beMask[i] = 1'b1;
  end

  // Integer encodings of the low part of the merged read data.
  wire        cSign;
  wire [63:0] cIndef;
  oaa_int_codec u_codec (
    .value       (rdData[63:0]),
    .size        (size_q),
    .signBit     (cSign),
    .indefinite  (cIndef),
    .unsignedMax (),
    .zeroExt     ()
  );

  // ==========================================================
  // Control sequence: one beat per boundary-bounded piece.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      addr_q <= 32'h0;
      left_q <= 5'h0;
      done_q <= 5'h0;
      size_q <= `OAA_SZ_BYTE;
      wr_q <= 1'b0;
      io_q <= 1'b0;
      wbuf_q <= 128'h0;
      busy <= 1'b0;
      done <= 1'b0;
      rdData <= 128'h0;
      generalProtectionFault <= 1'b0;
      badIndex <= 1'b0;
      segSel <= `OAA_SEG_DATA;
      rdSign <= 1'b0;
      intIndefinite <= 64'h0;
      busReq <= 1'b0;
      busWrite <= 1'b0;
      busIo <= 1'b0;
      busAddr <= 32'h0;
      busBe <= 8'h00;
      busWdata <= 64'h0;
    end else begin
      done <= 1'b0;
      generalProtectionFault <= 1'b0;
      rdSign <= cSign;
      intIndefinite <= cIndef;
      case (st_q)
        ST_IDLE: begin
          if (reqValid) begin
            badIndex <= indexEn && (indexSel == `OAA_REG_SP);
            segSel <= stackBase ? `OAA_SEG_STACK : `OAA_SEG_DATA;
            if (!reqIo && dqMisalign) begin
              generalProtectionFault <= 1'b1;
              done <= 1'b1;
            end else begin
              // I/O ports use a 16-bit address and sizes up to doubleword.
              addr_q <= reqIo ? {16'h0, ioPort} : effAddr;
              size_q <= (reqIo && reqSize > `OAA_SZ_DWORD) ? `OAA_SZ_DWORD : reqSize;
              left_q <= (reqIo && reqSize > `OAA_SZ_DWORD) ? 5'h04 : sizeBytes(reqSize);
              done_q <= 5'h0;
              wr_q <= reqWrite;
              io_q <= reqIo;
              wbuf_q <= wrData;
              rdData <= 128'h0;
              busy <= 1'b1;
              st_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          // Issue one beat; data lanes follow address bits, low byte first.
          busReq <= 1'b1;
          busWrite <= wr_q;
          busIo <= io_q;
          busAddr <= {addr_q[31:`OAA_BEAT_LSB], 3'h0};
          busBe <= beMask;
          busWdata <= wbuf_q[63:0] << {laneOff, 3'h0};
          st_q <= ST_BEAT;
        end
        ST_BEAT: begin
          if (busAck) begin
            busReq <= 1'b0;
            if (!wr_q)
              rdData <= rdData |
                ({64'h0, busRdata >> {laneOff, 3'h0}} << {done_q, 3'h0});
            wbuf_q <= wbuf_q >> {beatCnt, 3'h0};
            addr_q <= addr_q + {27'h0, beatCnt};
            done_q <= done_q + beatCnt;
            left_q <= left_q - beatCnt;
            // Completion waits for the last beat, read or write.
            st_q <= (left_q == beatCnt) ? ST_DONE : ST_NEXT;
          end
        end
        ST_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // oaa_access_unit

/* File: rtl/oaa_int_codec.v */
// Integer encoding helper: sign, ranges and indefinite value by size.
`timescale 1ns/10ps
`include "oaa_map.vh"

module oaa_int_codec (
  // Operand and size
  input  wire [63:0] value,
  input  wire [2:0]  size,
  // Results
  output reg         signBit,
  output reg  [63:0] indefinite,
  output reg  [63:0] unsignedMax,
  output reg  [63:0] zeroExt
);

  // Sign position, most negative value and unsigned limit by size.
  always @* begin
    case (size)
      `OAA_SZ_BYTE: begin
        signBit     = value[7];
        indefinite  = 64'h0000000000000080;
        unsignedMax = 64'h00000000000000FF;
        zeroExt     = {56'h0, value[7:0]};
      end
      `OAA_SZ_WORD: begin
        signBit     = value[15];
        indefinite  = 64'h0000000000008000;
        unsignedMax = 64'h000000000000FFFF;
        zeroExt     = {48'h0, value[15:0]};
      end
      `OAA_SZ_DWORD: begin
        signBit     = value[31];
        indefinite  = 64'h0000000080000000;
        unsignedMax = 64'h00000000FFFFFFFF;
        zeroExt     = {32'h0, value[31:0]};
      end
      default: begin
        signBit     = value[63];
        indefinite  = 64'h8000000000000000;
        unsignedMax = 64'hFFFFFFFFFFFFFFFF;
        zeroExt     = value;
      end
    endcase
  end

endmodule // oaa_int_codec

/* File: tb/oaa_access_checker.sv */
// Port timing checker bound to the operand access unit.
`timescale 1ns/10ps
module oaa_access_checker (
  // Request side
  input wire mclk,
  input wire rst,
  input wire reqValid,
  input wire reqIo,
  input wire [2:0] reqSize,
  input wire reqAlignReq,
  input wire baseEn,
  input wire [31:0] baseVal,
  input wire indexEn,
  input wire [2:0] indexSel,
  input wire [31:0] indexVal,
  input wire [1:0] scale,
  input wire [31:0] disp,
  // Answer and bus side
  input wire busy,
  input wire done,
  input wire generalProtectionFault,
  input wire badIndex,
  input wire busReq,
  input wire [31:0] busAddr,
  input wire [7:0] busBe,
  input wire busAck
);
  // ==========
  // Effective address; the stack pointer never acts as an index.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = reqValid && !busy && !done;
  wire spIdx = indexEn && indexSel == 3'h4;
  wire [31:0] ea = (baseEn ? baseVal : 32'h0) + (indexEn && !spIdx ? indexVal << scale : 32'h0)
    + disp;
  wire dqBad = !reqIo && reqSize == 3'h4 && reqAlignReq && ea[3:0] != 4'h0;
  a_fault_no_bus: assert property (generalProtectionFault |-> done && !busReq)
    else $error("fault without done or with bus");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than a cycle");
  a_bus_holds: assert property (busReq && !busAck |=> busReq && $stable({busAddr, busBe}))
    else $error("bus request changed before ack");
  a_dq_fault: assert property (take && dqBad |=> generalProtectionFault && done)
    else $error("misaligned operand not faulted");
  a_no_fault: assert property (take && !dqBad |=> !generalProtectionFault)
    else $error("unexpected fault");
  a_sp_index: assert property (take && spIdx |-> ##[1:2] badIndex)
    else $error("stack pointer index not flagged");
  a_take_bus: assert property (take && !dqBad |-> ##2 busReq)
    else $error("bus request not two cycles after take");
  a_ack_next: assert property (busReq && busAck |-> ##[1:3] (busReq || done))
    else $error("no beat or done after ack");
  a_busy_bus: assert property (busReq |-> busy)
    else $error("bus request while not busy");
  a_done_idle: assert property (done |-> !busy && !busReq)
    else $error("done while still busy or on the bus");
endmodule // oaa_access_checker

bind oaa_access_unit oaa_access_checker u_chk (.mclk, .rst, .reqValid, .reqIo, .reqSize,
  .reqAlignReq, .baseEn, .baseVal, .indexEn, .indexSel, .indexVal, .scale, .disp, .busy,
  .done, .generalProtectionFault, .badIndex, .busReq, .busAddr, .busBe, .busAck);

/* File: tb/oaa_bus_model.sv */
// Behavioural memory and I/O space on the far side of the bus.
`timescale 1ns/10ps
module oaa_bus_model (
  // Request
  input  wire         mclk,
  input  wire         busReq,
  input  wire         busWrite,
  input  wire         busIo,
  input  wire  [31:0] busAddr,
  input  wire  [7:0]  busBe,
  input  wire  [63:0] busWdata,
  input  wire  [2:0]  stall,
  // Answer
  output logic [63:0] busRdata,
  output logic        busAck
);
  logic [7:0]  mem [bit [32:0]];
  logic [32:0] key;
  int          cnt = 0;
  int          i;
  initial busAck = 1'b0;
  initial busRdata = 64'h0;
  // Stalls as asked; data toggles outside the ack cycle so stale reads show.
  always @(posedge mclk) begin
    busAck <= 1'b0;
    busRdata <= ~busRdata;
    if (busReq && !busAck && cnt < stall) cnt++;
    else if (busReq && !busAck) begin
      cnt = 0;
      busAck <= 1'b1;
      for (i = 0; i < 8; i++) begin
        key = {busIo, busAddr + i};
        if (busWrite && busBe[i]) mem[key] = busWdata[8*i +: 8];
        busRdata[8*i +: 8] <= mem.exists(key) ? mem[key] : key[7:0] ^ 8'hA5;
      end
    end
  end
endmodule // oaa_bus_model

/* File: tb/tb_top.sv */
// Self-checking bench of the operand access unit with a random request stream.
`timescale 1ns/10ps
`include "oaa_map.vh"
module tb_top;
  // ==========
  // Design signals and bench state
  logic         mclk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqIo = 1'b0;
  logic         reqIoImm = 1'b0, reqAlignReq = 1'b0, baseEn = 1'b0, indexEn = 1'b0;
  logic [2:0]   reqSize = 3'h0, baseSel = 3'h0, indexSel = 3'h0, stall = 3'h0;
  logic [1:0]   scale = 2'h0;
  logic [15:0]  ioImm = 16'h0, portIndexReg = 16'h0;
  logic [31:0]  baseVal = 32'h0, indexVal = 32'h0, disp = 32'h0, lfsr = 32'h2C, r, busAddr;
  logic [127:0] wrData = 128'h0, rdData;
  logic [63:0]  intIndefinite, busWdata, busRdata;
  logic [7:0]   busBe;
  logic         busy, done, generalProtectionFault, badIndex, segSel, rdSign;
  logic         busReq, busWrite, busIo, busAck;
  logic [7:0]   shadow [bit [32:0]];
  logic [11:0]  corner [9] = '{12'h101, 12'h103, 12'h206, 12'h308, 12'h30D, 12'h0FF,
                             12'hC10, 12'hC18, 12'h413};
  int           bad_count = 0, cmp_count = 0, beats = 0, i;
  oaa_access_unit u_dut (.mclk, .rst, .reqValid, .reqWrite, .reqIo, .reqIoImm, .reqSize,
    .reqAlignReq, .baseEn, .baseSel, .baseVal, .indexEn, .indexSel, .indexVal, .scale,
    .disp, .ioImm, .portIndexReg, .wrData, .busy, .done, .rdData, .generalProtectionFault,
    .badIndex, .segSel, .rdSign, .intIndefinite, .busReq, .busWrite, .busIo, .busAddr,
    .busBe, .busWdata, .busRdata, .busAck);
  oaa_bus_model u_bus (.mclk, .busReq, .busWrite, .busIo, .busAddr, .busBe, .busWdata,
    .stall, .busRdata, .busAck);
  // Clock; acknowledged beats are counted to check how accesses split.
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) if (busReq && busAck) beats++;
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(logic [127:0] seen, logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One request: expectations come first, since a store changes the shadow.
  task automatic op();
    int n, k, nb, lo;
    logic [31:0] a;
    logic [32:0] key;
    logic [127:0] rd, ex, mk;
    logic bad;
    n = 1 << (reqIo && reqSize > 3'h2 ? 2 : reqSize);
    a = reqIo ? {16'h0, reqIoImm ? ioImm : portIndexReg} : (baseEn ? baseVal : 32'h0)
      + (indexEn && indexSel != 3'h4 ? indexVal << scale : 32'h0) + disp;
    bad = !reqIo && reqSize == 3'h4 && reqAlignReq && a[3:0] != 4'h0;
    lo = n > 4 ? a[2:0] : a[1:0];
    nb = bad ? 0 : n > 4 ? (lo + n + 7) / 8 : (lo + n + 3) / 4;
    ex = 128'h0;
    mk = 128'h0;
    for (k = 0; k < n; k++) begin
      key = {reqIo, a + k};
      ex[8*k +: 8] = shadow.exists(key) ? shadow[key] : key[7:0] ^ 8'hA5;
      mk[8*k +: 8] = 8'hFF;
      if (reqWrite && !bad) shadow[key] = wrData[8*k +: 8];
    end
    beats = 0;
    @(negedge mclk) reqValid = 1'b1;
    @(negedge mclk) reqValid = 1'b0;
    for (k = 0; done !== 1'b1; k++) begin
      if (k > 300) begin
        bad_count++;
        final_report();
      end
      @(negedge mclk);
    end
    rd = rdData;
    chk(generalProtectionFault, bad);
    chk(busy, 1'b0);
    if (!reqWrite && !bad) chk(rd & mk, ex);
    @(negedge mclk);
    chk(beats, nb);
    if (!reqIo && reqSize < 3'h4 && !reqWrite) chk(rdSign, rd[8*n-1]);
    if (!reqIo && reqSize < 3'h4) chk(intIndefinite, 64'h1 << (8 * n - 1));
    if (!reqIo) chk(segSel, baseEn && (baseSel == 3'h4 || baseSel == 3'h5));
    if (!reqIo) chk(badIndex, indexEn && indexSel == 3'h4);
  endtask
  // Boundary cases stored then loaded back, then the random stream.
  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    for (i = 0; i < 18; i++) begin
      {reqAlignReq, reqSize, disp} = {corner[i / 2][11:8], 24'h0, corner[i / 2][7:0]};
      reqWrite = i % 2 == 0;
      wrData = {nxt(), nxt(), nxt(), nxt()};
      op();
    end
    for (i = 0; i < 200; i++) begin
      r = nxt();
      {reqWrite, reqIoImm, reqAlignReq, baseEn, indexEn} = r[4:0];
      reqIo = r[5] & r[6];
      reqSize = r[9:7] > 3'h4 ? 3'h2 : r[9:7];
      {baseSel, indexSel, scale, stall} = r[20:10];
      ioImm = {12'h0, r[24:21]};
      portIndexReg = {12'h0, r[28:25]};
      baseVal = nxt() & 32'h3F;
      indexVal = nxt() & 32'hF;
      disp = nxt() & 32'h1F;
      wrData = {nxt(), nxt(), nxt(), nxt()};
      op();
    end
    final_report();
  end
endmodule // tb_top
